// file: hw/bmc_pkg.sv
// shared constants and types for the bus master cycle control block
package bmc_pkg;
   // cycle states: idle, address state, wait/data state, inserted idle
   typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_WAIT, ST_TIDLE} bmc_state_t;
   localparam int         ADDR_W       = 32;
   localparam int         DATA_W       = 32;
   localparam int         WAIT_W       = 2;
   localparam logic       DIR_READ     = 1'h0;
   localparam logic       DIR_WRITE    = 1'h1;
   localparam logic       STROBE_OFF   = 1'h1;
   localparam logic       STROBE_ON    = 1'h0;
   localparam int         RST_HOLD_CYC = 10;   // least reset width, slow clock
   localparam int         SYNC_STAGES  = 2;
endpackage

// file: hw/bmc_term_if.sv
// termination qualifier link between the cycle controller and its sampler
`timescale 1ns/1ps
`default_nettype none
interface bmc_term_if;
   logic async_mode;
   logic style_sel;
   logic term_sync;
   logic term_async;
   modport qual (input async_mode, input style_sel,
                 output term_sync, output term_async);
   modport ctl  (output async_mode, output style_sel,
                 input term_sync, input term_async);
endinterface
`default_nettype wire

// file: hw/bmc_term_qual.sv
// ready / acknowledge sampler that qualifies cycle termination
`timescale 1ns/1ps
`default_nettype none
module bmc_term_qual
   import bmc_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_ready_in_n,
   input  wire logic [1:0] i_size_ack_pair_n,
   bmc_term_if.qual        term
);
   typedef struct packed {
      logic rdy_low;
   } bmc_qs_t;

   bmc_qs_t s_q;
   bmc_qs_t s_d;

   // =========================================================
   // ready sample
   // ready is caught once per clock and only the captured copy ends an
   // asynchronous cycle, so the far side need not align it
   always_comb begin
      s_d         = s_q;
      // armed only for the asynchronous ready style, so a capture taken
      // in another mode cannot end the first asynchronous cycle
      s_d.rdy_low = term.async_mode & ~term.style_sel & ~i_ready_in_n;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // =========================================================
   // termination terms
   // alternate style takes either acknowledge, already clock aligned
   assign term.term_sync  = term.style_sel ? ~&i_size_ack_pair_n
                                           : ~i_ready_in_n;
   assign term.term_async = s_q.rdy_low;
endmodule
`default_nettype wire

// file: hw/bmc_cycle_ctl.sv
// bus master memory cycle controller: strobes, direction, wait states
//
// Notes on behaviour
// - data strobe only in cycles with waits
// - one idle cycle after descriptor write, only when a descriptor read follows
// - data drivers released after that idle
// - async ready sampled and held internally
// - captured async ready ends cycle next clock
// - zero waits: two or three clocks
// - direction stays read across read cycles
`timescale 1ns/1ps
`default_nettype none
module bmc_cycle_ctl
   import bmc_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
)(
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_async_mode,
   input  wire logic              i_bus_style_select,
   input  wire logic [WAIT_W-1:0] i_wait_states,
   input  wire logic              i_req,
   input  wire logic              i_req_write,
   input  wire logic              i_req_desc,
   input  wire logic [AW-1:0]     i_req_addr,
   input  wire logic [DW-1:0]     i_req_wdata,
   input  wire logic              i_ready_in_n,
   input  wire logic [1:0]        i_size_ack_pair_n,
   input  wire logic [DW-1:0]     i_data_in,
   output logic                   o_addr_strobe_n,
   output logic                   o_early_cycle_strobe_n,
   output logic                   o_data_strobe_n,
   output logic                   o_write_read_dir,
   output logic [AW-1:0]          o_addr,
   output logic [DW-1:0]          o_data_out,
   output logic                   o_data_oe,
   output logic                   o_done,
   output logic [DW-1:0]          o_rdata,
   output logic                   o_busy
);
   typedef struct packed {
      bmc_state_t        st;
      logic              ads_n;
      logic              ecs_n;
      logic              ds_n;
      logic              dir;
      logic [AW-1:0]     addr;
      logic [DW-1:0]     wdata;
      logic              doe;
      logic              done;
      logic [DW-1:0]     rdata;
      logic              busy;
      logic              wr;
      logic              desc_wr_last;
      logic [WAIT_W-1:0] wcnt;
   } bmc_cs_t;

   logic [SYNC_STAGES-1:0] rst_sync_q;
   logic                   rst_n;
   bmc_cs_t                s_q;
   bmc_cs_t                s_d;
   logic                   term_hit;
   bmc_term_if             term_link ();

   // =========================================================
   // reset release
   // the source must already have held the pin low long enough
   // this only removes release metastability
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_sync_q <= '0;
      end else begin
         rst_sync_q <= {rst_sync_q[SYNC_STAGES-2:0], 1'h1};
      end
   end
   assign rst_n = rst_sync_q[SYNC_STAGES-1];

   // =========================================================
   // termination sampler
   assign term_link.async_mode = i_async_mode;
   assign term_link.style_sel  = i_bus_style_select;

   bmc_term_qual u_qual (
      .i_clk             (i_clk),
      .i_rst_n           (rst_n),
      .i_ready_in_n      (i_ready_in_n),
      .i_size_ack_pair_n (i_size_ack_pair_n),
      .term              (term_link.qual)
   );

   // async only for the ready style; acks of the other style are synchronous
   assign term_hit = (i_async_mode && !i_bus_style_select)
                   ? term_link.term_async : term_link.term_sync;

   // =========================================================
   // cycle sequencer
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'h0;
      unique case (s_q.st)
         ST_IDLE: begin
            s_d.busy = 1'h0;
            if (i_req) begin
               s_d.busy  = 1'h1;
               s_d.addr  = i_req_addr;
               s_d.wdata = i_req_wdata;
               s_d.wr    = i_req_write;
               if (s_q.desc_wr_last && i_req_desc && !i_req_write) begin
                  s_d.st = ST_TIDLE;
               end else begin
                  s_d.st    = ST_FIRST;
                  s_d.ads_n = STROBE_ON;
                  s_d.ecs_n = STROBE_ON;
                  s_d.dir   = i_req_write ? DIR_WRITE : DIR_READ;
                  s_d.doe   = i_req_write;
               end
               s_d.desc_wr_last = 1'h0;
            end else begin
               s_d.doe = 1'h0;
            end
         end
         ST_TIDLE: begin
            // drivers held through the idle cycle, off from the next edge
            s_d.doe   = 1'h0;
            s_d.st    = ST_FIRST;
            s_d.ads_n = STROBE_ON;
            s_d.ecs_n = STROBE_ON;
            s_d.dir   = DIR_READ;
         end
         ST_FIRST: begin
            s_d.ads_n = STROBE_OFF;
            s_d.ecs_n = STROBE_OFF;
            s_d.wcnt  = i_wait_states;
            s_d.st    = ST_WAIT;
         end
         ST_WAIT: begin
            if (s_q.wcnt == '0 && term_hit) begin
               s_d.st    = ST_IDLE;
               s_d.ds_n  = STROBE_OFF;
               s_d.done  = 1'h1;
               s_d.busy  = 1'h0;
               s_d.desc_wr_last = s_q.wr && i_req_desc;
               s_d.doe   = s_q.wr && i_req_desc;
               if (!s_q.wr) begin
                  s_d.rdata = i_data_in;
               end
            end else begin
               // a wait state follows, so only now the data strobe goes low
               s_d.ds_n = STROBE_ON;
               if (s_q.wcnt != '0) begin
                  s_d.wcnt = s_q.wcnt - 1'h1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q       <= '0;
         s_q.st    <= ST_IDLE;
         s_q.ads_n <= STROBE_OFF;
         s_q.ecs_n <= STROBE_OFF;
         s_q.ds_n  <= STROBE_OFF;
         s_q.dir   <= DIR_READ;
      end else begin
         s_q <= s_d;
      end
   end

   // =========================================================
   // outputs straight from the state register
   assign o_addr_strobe_n        = s_q.ads_n;
   assign o_early_cycle_strobe_n = s_q.ecs_n;
   assign o_data_strobe_n        = s_q.ds_n;
   assign o_write_read_dir       = s_q.dir;
   assign o_addr                 = s_q.addr;
   assign o_data_out             = s_q.wdata;
   assign o_data_oe              = s_q.doe;
   assign o_done                 = s_q.done;
   assign o_rdata                = s_q.rdata;
   assign o_busy                 = s_q.busy;

   // =========================================================
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!rst_n);

   AST_DS_WAIT_ONLY: assert property (
      !o_data_strobe_n |-> s_q.st == ST_WAIT && $past(s_q.st) == ST_WAIT)
      else $error("data strobe outside a wait state");
   AST_ONE_IDLE: assert property (
      s_q.st == ST_TIDLE |=> s_q.st == ST_FIRST)
      else $error("idle insertion not one cycle");
   AST_IDLE_CAUSE: assert property (
      s_q.st == ST_TIDLE |-> $past(s_q.desc_wr_last))
      else $error("idle cycle without preceding descriptor write");
   AST_RELEASE: assert property (
      s_q.st == ST_TIDLE |=> !o_data_oe && !o_write_read_dir)
      else $error("data bus still driven after idle cycle");
   AST_ASYNC_END: assert property (
      (i_async_mode && !i_bus_style_select && s_q.st == ST_WAIT
       && s_q.wcnt == '0 && term_link.term_async)
      |=> o_done && s_q.st == ST_IDLE)
      else $error("async ready did not end cycle on next clock");
   AST_ASYNC_SAMPLED: assert property (
      (i_async_mode && !i_bus_style_select && s_q.st == ST_WAIT
       && s_q.wcnt == '0 && $past(i_ready_in_n)) |=> !o_done)
      else $error("async ready used without its captured sample");
   AST_TWO_CLK: assert property (
      (s_q.st == ST_FIRST && i_wait_states == '0)
      ##1 term_hit |=> o_done && $past(s_q.st, 2) == ST_FIRST)
      else $error("zero wait access not two clocks");
   AST_DIR_HOLD: assert property (
      (o_write_read_dir == DIR_READ
       && !(s_q.st == ST_IDLE && i_req && i_req_write))
      |=> o_write_read_dir == DIR_READ)
      else $error("direction toggled between reads");
   AST_SYNC_END: assert property (
      (!i_async_mode && !i_bus_style_select && s_q.st == ST_WAIT
       && s_q.wcnt == '0 && !i_ready_in_n) |=> o_done)
      else $error("synchronous ready did not end cycle");
   AST_ADS_FIRST: assert property (
      (s_q.st == ST_FIRST) == !o_addr_strobe_n)
      else $error("address strobe not framing first state");

   COV_ZERO_WAIT: cover property (s_q.st == ST_FIRST ##2 o_done);
   COV_WAIT_DS: cover property (!o_data_strobe_n ##1 o_done);
   COV_TIDLE: cover property (s_q.st == ST_TIDLE ##1 s_q.st == ST_FIRST);
   COV_ASYNC: cover property (i_async_mode && o_done);
endmodule
`default_nettype wire

// file: dv/bmc_mem_model.sv
// memory side responder that ends each cycle on ready or acknowledge
`timescale 1ns/1ps
`default_nettype none
module bmc_mem_model (
   input  wire logic        i_clk,
   input  wire logic        i_ads_n,
   input  wire logic        i_dir,
   input  wire logic        i_done,
   input  wire logic        i_style,
   input  wire logic        i_early,
   input  wire logic [3:0]  i_lat,
   input  wire logic [31:0] i_addr,
   input  wire logic [31:0] i_dout,
   output logic             o_ready_n,
   output logic [1:0]       o_ack_n,
   output logic [31:0]      o_din,
   output logic [31:0]      o_wseen
);
   // ==========================================
   // cycle tracking
   logic       act;
   logic [3:0] cnt;
   logic       rdy;
   initial begin
      act = 1'b0;
      cnt = 4'h0;
      o_wseen = 32'h0;
   end
   // a cycle opens on the edge that sees the address strobe low
   always @(posedge i_clk) begin
      if (!i_ads_n) begin
         act <= 1'b1;
         cnt <= i_lat;
      end else if (i_done) begin
         act <= 1'b0;
      end else if (act && cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
      if (rdy && i_dir) begin
         o_wseen <= i_dout;
      end
   end
   // answer drops once done shows, so no stale ready leaks onward
   assign rdy = ((act && cnt == 4'h0) || (i_early && !i_ads_n)) && !i_done;
   // late, unaligned edges; acks still change only after a clock edge
   assign #13 o_ready_n = i_style ? 1'b1 : !rdy;
   assign #13 o_ack_n = i_style ? {1'b1, !rdy} : 2'h3;
   // bus not driven with valid data shows the inverse pattern
   assign o_din = rdy ? {~i_addr[15:0], i_addr[15:0]}
                      : {i_addr[15:0], ~i_addr[15:0]};
endmodule
`default_nettype wire

// file: dv/bus_master_cycle_control_tb.sv
// self-checking bench for the bus master cycle controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
   $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module bus_master_cycle_control_tb;
   import bmc_pkg::*;
   logic        i_clk, i_rst_n, am, st, rq, rw, rd, ea, rdy_n;
   logic        ads_n, ecs_n, ds_n, dir, oe, done, busy, dss, dbad, oea, bz;
   logic [1:0]  ws, ack_n;
   logic [3:0]  lat;
   logic [31:0] ra, wd, din, wseen, addr, dout, rdata;
   int          fails = 0;
   int          tests_run = 0;
   int          nd, na, nl, ne;
   bmc_cycle_ctl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_async_mode(am),
      .i_bus_style_select(st), .i_wait_states(ws), .i_req(rq),
      .i_req_write(rw), .i_req_desc(rd), .i_req_addr(ra),
      .i_req_wdata(wd), .i_ready_in_n(rdy_n), .i_size_ack_pair_n(ack_n),
      .i_data_in(din), .o_addr_strobe_n(ads_n),
      .o_early_cycle_strobe_n(ecs_n), .o_data_strobe_n(ds_n),
      .o_write_read_dir(dir), .o_addr(addr), .o_data_out(dout),
      .o_data_oe(oe), .o_done(done), .o_rdata(rdata), .o_busy(busy));
   bmc_mem_model mem (.i_clk(i_clk), .i_ads_n(ads_n), .i_dir(dir),
      .i_done(done), .i_style(st), .i_early(ea), .i_lat(lat),
      .i_addr(addr), .i_dout(dout), .o_ready_n(rdy_n), .o_ack_n(ack_n),
      .o_din(din), .o_wseen(wseen));
   // ==========================================
   // access tasks
   task automatic wrap_up();
      if (fails == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // request held on so a following call runs back to back
   task automatic run(input logic w, d, e, input logic [3:0] l,
                      input logic [31:0] a);
      int k;
      rq <= 1'b1;
      rw <= w;
      rd <= d;
      ea <= e;
      lat <= l;
      ra <= a;
      wd <= ~a;
      nd = 0;
      na = 0;
      nl = 0;
      ne = 0;
      dss = 1'b0;
      dbad = 1'b0;
      for (k = 1; k < 30 && nd == 0; k++) begin
         @(negedge i_clk);
         if (na == 0 && ads_n === STROBE_ON) begin
            na = k;
            oea = oe;
            bz = busy;
         end
         // both strobes frame only the first state of each cycle
         if (ads_n === STROBE_ON) nl++;
         if (ecs_n === STROBE_ON) ne++;
         if (na != 0 && dir !== w) dbad = 1'b1;
         if (ds_n === STROBE_ON) dss = 1'b1;
         if (done === 1'b1) nd = k;
      end
   endtask
   task automatic idle();
      rq <= 1'b0;
      repeat (3) @(negedge i_clk);
   endtask
   // ==========================================
   // clock, watchdog and tests
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   // the whole sequence needs well under a hundred cycles; ample margin here
   initial begin
      repeat (3000) @(posedge i_clk);
      fails++;
      wrap_up();
   end
   initial begin
      {i_rst_n, am, st, rq, rw, rd, ea} = 7'h0;
      ws = 2'h0;
      lat = 4'h0;
      ra = 32'h0;
      wd = 32'h0;
      repeat (2 * RST_HOLD_CYC) @(negedge i_clk);
      i_rst_n <= 1'b1;
      repeat (4) @(negedge i_clk);
      `CHK({ads_n, ds_n, dir, oe, done, busy}, 6'h30)
      run(0, 0, 0, 4'h0, 32'h0000_1234);
      `CHK(nd, 3)
      `CHK(dss, 1'b0)
      `CHK(rdata, 32'hedcb_1234)
      `CHK(nl, 1)
      `CHK(ne, 1)
      `CHK(bz, 1'b1)
      run(0, 0, 0, 4'h2, 32'h0000_00f0);
      `CHK(nd, 5)
      `CHK(dss, 1'b1)
      `CHK(dbad, 1'b0)
      `CHK(rdata, 32'hff0f_00f0)
      run(1, 0, 0, 4'h1, 32'h0000_0a0a);
      `CHK(nd, 4)
      `CHK(dbad, 1'b0)
      `CHK(wseen, 32'hffff_f5f5)
      run(1, 1, 0, 4'h0, 32'h0000_0010);
      run(0, 1, 0, 4'h0, 32'h0000_0020);
      `CHK(na, 2)
      `CHK(oea, 1'b0)
      `CHK(nd, 4)
      `CHK(nl, 1)
      idle();
      am <= 1'b1;
      run(0, 0, 1, 4'h0, 32'h0000_0030);
      `CHK(nd, 3)
      run(0, 0, 0, 4'h0, 32'h0000_0040);
      `CHK(nd, 4)
      run(0, 0, 0, 4'h3, 32'h0000_0050);
      `CHK(nd, 7)
      `CHK(rdata, 32'hffaf_0050)
      `CHK(ne, 1)
      idle();
      am <= 1'b0;
      st <= 1'b1;
      run(0, 0, 0, 4'h1, 32'h0000_0060);
      `CHK(nd, 4)
      `CHK(dss, 1'b1)
      idle();
      st <= 1'b0;
      ws <= 2'h1;
      run(0, 0, 0, 4'h0, 32'h0000_0070);
      `CHK(nd, 4)
      idle();
      wrap_up();
   end
endmodule
`default_nettype wire
